// [common/bf_pkg.sv]
package bf_pkg;
  // operating criterion
  typedef enum logic [1:0] {
    CRIT_CURRENT,
    CRIT_CUR_AND_DO,
    CRIT_CUR_OR_DO
  } crit_t;

  localparam int CLK_HZ = 10_000_000;
  localparam int CYCLE_US = 5_000; // program cycle equals one delay step, 5 ms
  localparam int CYCLE_CLKS = CYCLE_US * (CLK_HZ / 1_000_000);
  localparam int DLY_W = 19; // enough steps for 1800 s in 5 ms units
  localparam int RETRIP_MS_DEF = 100;
  localparam int CBF_MS_DEF = 200;
  localparam int STEP_MS = 5;
  localparam logic [DLY_W-1:0] RETRIP_STEPS_DEF = DLY_W'(RETRIP_MS_DEF / STEP_MS);
  localparam logic [DLY_W-1:0] CBF_STEPS_DEF = DLY_W'(CBF_MS_DEF / STEP_MS);

  // avalon register map, byte addresses
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_RETRIP_DLY = 5'h04;
  localparam logic [4:0] ADDR_CBF_DLY = 5'h08;
  localparam logic [4:0] ADDR_STATUS = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h10;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h14;

  // control fields
  localparam int CTRL_CRIT_LSB = 0;
  localparam int CTRL_RETRIP_EN = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004; // current mode, retrip on

  // event / status bits
  localparam int EV_START = 0;
  localparam int EV_RETRIP = 1;
  localparam int EV_CBF = 2;
  localparam int EV_BLOCKED = 3;
  localparam int EV_W = 4;
endpackage

// [design/cycle_tick.sv]
`timescale 1ns/1ps
// program cycle strobe, one clock wide every PERIOD clocks
module cycle_tick #(
  parameter int PERIOD = bf_pkg::CYCLE_CLKS
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // async reset
  output logic tick_o // one-cycle strobe
);
  localparam logic [31:0] LAST = 32'(PERIOD - 1);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_tick;

  // wrap counter
  always_comb begin
    next_cnt = (cnt == LAST) ? '0 : cnt + 32'h0000_0001;
    next_tick = (cnt == LAST);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick_o <= next_tick;
    end
  end
endmodule

// [design/delay_stage.sv]
`timescale 1ns/1ps
// one delay timer: counts program cycles while armed, output a level
module delay_stage #(
  parameter int W = bf_pkg::DLY_W
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // async reset
  input wire logic tick_i, // program cycle strobe
  input wire logic run_i, // pick-up condition, timer may count
  input wire logic clr_i, // clear timer and output
  input wire logic [W-1:0] delay_i, // delay in program cycles
  output logic hit_o // delay elapsed while armed
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_hit;

  // halt keeps the count, clear drops it at once
  always_comb begin
    next_cnt = cnt;
    next_hit = hit_o;
    if (clr_i) begin
      next_cnt = '0;
      next_hit = 1'b0;
    end else if (tick_i && run_i) begin
      if (cnt < delay_i) begin
        next_cnt = cnt + W'(1);
      end
      next_hit = (cnt + W'(1) >= delay_i);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
      hit_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      hit_o <= next_hit;
    end
  end
endmodule

// [design/breaker_failure_timer_logic.sv]
`timescale 1ns/1ps
module breaker_failure_timer_logic
  import bf_pkg::*;
#(
  parameter int CYCLE = bf_pkg::CYCLE_CLKS // clocks per program cycle
) (
  input wire logic clk_i, // 10 MHz clock
  input wire logic rst_i, // async reset, high
  input wire logic phase_pickup_threshold_i, // phase current above pick-up
  input wire logic residual_pickup_threshold_i, // residual current above pick-up
  input wire logic trip_contact_i, // monitored primary trip contact
  input wire logic block_i, // block input
  input wire logic [4:0] avs_address_i, // avalon byte address
  input wire logic avs_read_i, // avalon read
  input wire logic avs_write_i, // avalon write
  input wire logic [31:0] avs_writedata_i, // avalon write data
  input wire logic [3:0] avs_byteenable_i, // avalon byte enables
  output logic [31:0] avs_readdata_o, // avalon read data
  output logic avs_waitrequest_o, // avalon wait
  output logic retrip_o, // second-coil retrip
  output logic breaker_failure_output_o, // upstream breaker trip
  output logic blocked_o, // blocked indication
  output logic irq_o // level interrupt
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;

  // pins come from relay logic outside this clock
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {block_i, trip_contact_i, residual_pickup_threshold_i, phase_pickup_threshold_i};
      sync2 <= sync1;
    end
  end

  logic cur_s;
  logic trip_s;
  logic blk_s;
  assign cur_s = sync2[0] | sync2[1];
  assign trip_s = sync2[2];
  assign blk_s = sync2[3];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0] ctrl;
  logic [DLY_W-1:0] retrip_dly;
  logic [DLY_W-1:0] cbf_dly;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] irq_mask;
  logic [31:0] next_ctrl;
  logic [DLY_W-1:0] next_retrip_dly;
  logic [DLY_W-1:0] next_cbf_dly;
  logic [EV_W-1:0] next_irq_mask;
  logic [EV_W-1:0] next_irq_stat;
  logic [31:0] next_rdata;
  logic next_wait;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] live;

  crit_t crit;
  logic retrip_en;
  assign crit = crit_t'(ctrl[CTRL_CRIT_LSB +: 2]);
  assign retrip_en = ctrl[CTRL_RETRIP_EN];

  // ------------------------------------------------------------
  // program cycle and pick-up
  // ------------------------------------------------------------
  logic tick;
  cycle_tick #(.PERIOD(CYCLE)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  logic pickup;
  logic started;
  logic blocked;
  logic next_started;
  logic next_blocked;

  // pick-up term per criterion; unknown code treated as current only
  always_comb begin
    unique case (crit)
      CRIT_CUR_AND_DO: pickup = cur_s & trip_s;
      CRIT_CUR_OR_DO: pickup = cur_s | trip_s;
      default: pickup = cur_s;
    endcase
  end

  // block is judged on the program cycle; a block during pick-up drops start and clears both timers until pick-up falls
  always_comb begin
    next_started = started;
    next_blocked = blocked;
    if (!pickup) begin
      next_started = 1'b0;
      next_blocked = 1'b0;
    end else if (tick) begin
      if (blk_s) begin
        next_started = 1'b0;
        next_blocked = 1'b1;
      end else if (!blocked) begin
        next_started = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      started <= 1'b0;
      blocked <= 1'b0;
    end else begin
      started <= next_started;
      blocked <= next_blocked;
    end
  end

  // both timers share the same pick-up; loss of pick-up clears at once
  logic run;
  logic clr;
  logic retrip_hit;
  logic cbf_hit;
  assign run = pickup & started;
  assign clr = ~pickup | ~started;

  delay_stage #(.W(DLY_W)) u_retrip (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .run_i(run & retrip_en),
    .clr_i(clr | ~retrip_en),
    .delay_i(retrip_dly),
    .hit_o(retrip_hit)
  );

  delay_stage #(.W(DLY_W)) u_cbf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .run_i(run),
    .clr_i(clr),
    .delay_i(cbf_dly),
    .hit_o(cbf_hit)
  );

  // ------------------------------------------------------------
  // outputs and interrupt
  // ------------------------------------------------------------
  logic next_retrip;
  logic next_cbf;
  logic next_irq;
  logic [EV_W-1:0] live_q;

  // outputs are levels that drop with pick-up
  always_comb begin
    next_retrip = retrip_hit & run & retrip_en;
    next_cbf = cbf_hit & run;
    live = {blocked, next_cbf, next_retrip, started};
    events = live & ~live_q; // rising edges only
    next_irq = |((irq_stat | events) & irq_mask);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      retrip_o <= 1'b0;
      breaker_failure_output_o <= 1'b0;
      blocked_o <= 1'b0;
      live_q <= '0;
      irq_o <= 1'b0;
    end else begin
      retrip_o <= next_retrip;
      breaker_failure_output_o <= next_cbf;
      blocked_o <= blocked;
      live_q <= live;
      irq_o <= next_irq;
    end
  end

  // ------------------------------------------------------------
  // avalon slave: one wait cycle, answer on the second edge
  // ------------------------------------------------------------
  logic req;
  logic wr_go;
  logic [31:0] be_mask;
  assign req = avs_read_i | avs_write_i;
  assign wr_go = avs_write_i & ~avs_waitrequest_o;
  assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  always_comb begin
    next_ctrl = ctrl;
    next_retrip_dly = retrip_dly;
    next_cbf_dly = cbf_dly;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_wait = ~(req & avs_waitrequest_o);
    next_rdata = avs_readdata_o; // read data hold until the next read is taken
    if (wr_go) begin
      unique case (avs_address_i)
        ADDR_CTRL: next_ctrl = ((ctrl & ~be_mask) | (avs_writedata_i & be_mask)) &
                               32'h0000_0007;
        ADDR_RETRIP_DLY: next_retrip_dly = DLY_W'((32'(retrip_dly) & ~be_mask) |
                                                  (avs_writedata_i & be_mask));
        ADDR_CBF_DLY: next_cbf_dly = DLY_W'((32'(cbf_dly) & ~be_mask) |
                                            (avs_writedata_i & be_mask));
        ADDR_IRQ_STAT: next_irq_stat = irq_stat & ~EV_W'(avs_writedata_i & be_mask);
        ADDR_IRQ_MASK: next_irq_mask = EV_W'((32'(irq_mask) & ~be_mask) |
                                             (avs_writedata_i & be_mask));
        default: ;
      endcase
    end
    next_irq_stat = next_irq_stat | events; // set beats clear
    if (avs_read_i & avs_waitrequest_o) begin
      unique case (avs_address_i)
        ADDR_CTRL: next_rdata = ctrl;
        ADDR_RETRIP_DLY: next_rdata = 32'(retrip_dly);
        ADDR_CBF_DLY: next_rdata = 32'(cbf_dly);
        ADDR_STATUS: next_rdata = 32'(live_q);
        ADDR_IRQ_STAT: next_rdata = 32'(irq_stat);
        ADDR_IRQ_MASK: next_rdata = 32'(irq_mask);
        default: next_rdata = '0; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
      retrip_dly <= RETRIP_STEPS_DEF;
      cbf_dly <= CBF_STEPS_DEF;
      irq_stat <= '0;
      irq_mask <= '0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= '0;
    end else begin
      ctrl <= next_ctrl;
      retrip_dly <= next_retrip_dly;
      cbf_dly <= next_cbf_dly;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      avs_waitrequest_o <= next_wait;
      avs_readdata_o <= next_rdata;
    end
  end
endmodule

// [test/bf_sva.sv]
`timescale 1ns/1ps
// ----
// checker on the top ports; the program cycle is CYCLE clocks
// ----
module bf_sva #(
  parameter int CYCLE = 10
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // async reset
  input wire logic phase_pickup_threshold_i, // phase pick-up
  input wire logic residual_pickup_threshold_i, // residual pick-up
  input wire logic trip_contact_i, // trip contact
  input wire logic block_i, // block
  input wire logic avs_read_i, // read
  input wire logic avs_write_i, // write
  input wire logic [31:0] avs_readdata_o, // read data
  input wire logic avs_waitrequest_o, // wait
  input wire logic retrip_o, // retrip
  input wire logic breaker_failure_output_o, // upstream trip
  input wire logic blocked_o // blocked
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // phase plus contact with no block picks up under every criterion
  wire any_in = phase_pickup_threshold_i | residual_pickup_threshold_i | trip_contact_i;
  wire both_in = phase_pickup_threshold_i & trip_contact_i & ~block_i;
  sequence quiet_s;
    !any_in [*5];
  endsequence
  sequence held_s;
    both_in [*4];
  endsequence
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low two cycles");
  a_wait_cause: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i | avs_write_i))
    else $error("answer without request");
  a_rdata_hold: assert property (avs_waitrequest_o && $past(avs_waitrequest_o) |->
    $stable(avs_readdata_o)) else $error("read data moved while idle");
  a_quiet_clear: assert property (quiet_s |=> !retrip_o && !breaker_failure_output_o && !blocked_o)
    else $error("output stands without pick-up");
  a_cbf_hold: assert property (held_s ##0 breaker_failure_output_o |=> breaker_failure_output_o)
    else $error("upstream trip dropped under pick-up");
  a_retrip_hold: assert property (held_s ##0 retrip_o |=> retrip_o)
    else $error("retrip dropped under pick-up");
  a_cbf_cause: assert property ($rose(breaker_failure_output_o) |-> $past(any_in, CYCLE))
    else $error("upstream trip too early");
  a_retrip_cause: assert property ($rose(retrip_o) |-> $past(any_in, CYCLE))
    else $error("retrip too early");
  a_block_cause: assert property ($rose(blocked_o) |-> $past(block_i, 2) || $past(block_i, 3) ||
    $past(block_i, 4) || $past(block_i, 5)) else $error("blocked without block");
endmodule

bind breaker_failure_timer_logic bf_sva #(.CYCLE(CYCLE)) bf_sva_inst (
  .clk_i(clk_i), .rst_i(rst_i), .phase_pickup_threshold_i(phase_pickup_threshold_i),
  .residual_pickup_threshold_i(residual_pickup_threshold_i), .trip_contact_i(trip_contact_i),
  .block_i(block_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .retrip_o(retrip_o),
  .breaker_failure_output_o(breaker_failure_output_o), .blocked_o(blocked_o));

// [test/bf_primary_model.sv]
`timescale 1ns/1ps
// primary stage and current path; slow_i delays every flag by three more clocks, four in all
module bf_primary_model (
  input wire logic clk_i, // clock
  input wire logic rst_i, // async reset
  input wire logic fault_i, // fault current flows
  input wire logic res_sel_i, // fault seen on residual only
  input wire logic trip_req_i, // primary stage trips
  input wire logic slow_i, // slow contact and measurement
  output logic phase_o, // phase above pick-up
  output logic residual_o, // residual above pick-up
  output logic contact_o // trip contact energized
);
  logic [11:0] sh, next_sh;
  // both edges lag alike, so a short drop keeps its length at the pins
  always_comb begin
    next_sh = {sh[8:0], fault_i & ~res_sel_i, fault_i & res_sel_i, trip_req_i};
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh <= 12'h000;
    end else begin
      sh <= next_sh;
    end
  end
  assign {phase_o, residual_o, contact_o} = slow_i ? sh[11:9] : sh[2:0];
endmodule

// [test/breaker_failure_timer_logic_tb_top.sv]
`timescale 1ns/1ps
module breaker_failure_timer_logic_tb_top;
  import bf_pkg::*;
  logic clk_i = 0, rst_i = 1, block_i = 0, avs_read_i = 0, avs_write_i = 0;
  logic fault = 0, res_sel = 0, trip_req = 0, slow = 0, ph, res, con;
  logic [4:0] avs_address_i = 5'h00;
  logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic avs_waitrequest_o, retrip_o, breaker_failure_output_o, blocked_o, irq_o;
  logic [63:0] exp_q[$];
  logic [5:0] tbl[8] = '{6'h0B, 6'h06, 6'h1A, 6'h1F, 6'h16, 6'h27, 6'h2B, 6'h09};
  int n_mismatch = 0, cmp_count = 0;
  always #50 clk_i = ~clk_i;
  breaker_failure_timer_logic #(.CYCLE(10)) breaker_failure_timer_logic_inst (.clk_i(clk_i),
    .rst_i(rst_i), .phase_pickup_threshold_i(ph), .residual_pickup_threshold_i(res),
    .trip_contact_i(con), .block_i(block_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .retrip_o(retrip_o),
    .breaker_failure_output_o(breaker_failure_output_o), .blocked_o(blocked_o), .irq_o(irq_o));
  bf_primary_model bf_primary_model_inst (.clk_i(clk_i), .rst_i(rst_i), .fault_i(fault),
    .res_sel_i(res_sel), .trip_req_i(trip_req), .slow_i(slow), .phase_o(ph), .residual_o(res),
    .contact_o(con));
  // ----
  // checking and bus tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // a read notes {mask, value}; the edge gap keeps strobes from double assignment
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    @(posedge clk_i);
    if (!wr) exp_q.push_back({m, d});
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  // read data compared at the edge that takes it
  always @(posedge clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0) begin
      chk(avs_readdata_o & exp_q[0][63:32], exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
  end
  task automatic settle();
    fault <= 1'b0;
    trip_req <= 1'b0;
    cyc(10);
    chk({retrip_o, breaker_failure_output_o}, 2'b00);
  endtask
  // c: {criterion, current, contact, retrip enable, fires}
  task automatic run_case(input logic [5:0] c);
    bus(1, ADDR_CTRL, {29'h0000_0000, c[1], c[5:4]}, 0);
    fault <= c[3];
    res_sel <= 1'($urandom_range(1));
    trip_req <= c[2];
    slow <= 1'($urandom_range(1));
    cyc(15);
    chk({retrip_o, breaker_failure_output_o}, 2'b00);
    cyc(50);
    chk(retrip_o, c[0] & c[1]);
    chk(breaker_failure_output_o, c[0]);
    bus(0, ADDR_STATUS, {29'h0000_0000, c[0], c[0] & c[1], 1'b0}, 32'h0000_0006);
    settle();
  endtask
  // short drop of one term in mid-count; dc picks current, else contact
  task automatic glitch(input logic [1:0] cr, input logic dc, input logic fires);
    bus(1, ADDR_CTRL, {29'h0000_0000, 1'b1, cr}, 0);
    fault <= 1'b1;
    trip_req <= 1'b1;
    cyc(30);
    if (dc) fault <= 1'b0;
    else trip_req <= 1'b0;
    cyc(5);
    fault <= 1'b1;
    trip_req <= 1'b1;
    cyc(25);
    chk(breaker_failure_output_o, fires);
    settle();
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(87));
    cyc(12);
    rst_i <= 1'b0;
    bus(0, ADDR_CTRL, 32'h0000_0004, 32'hFFFF_FFFF);
    bus(0, ADDR_RETRIP_DLY, 32'h0000_0014, 32'hFFFF_FFFF);
    bus(0, ADDR_CBF_DLY, 32'h0000_0028, 32'hFFFF_FFFF);
    bus(0, ADDR_IRQ_MASK, 32'h0000_0000, 32'hFFFF_FFFF);
    bus(1, 5'h1C, 32'hFFFF_FFFF, 0);
    bus(0, 5'h1C, 32'h0000_0000, 32'hFFFF_FFFF);
    bus(1, ADDR_RETRIP_DLY, 32'h0000_0002, 0);
    bus(1, ADDR_CBF_DLY, 32'h0000_0004, 0);
    bus(1, ADDR_IRQ_MASK, 32'h0000_0004, 0);
    foreach (tbl[i]) run_case(tbl[i]);
    chk(irq_o, 1'b1);
    bus(0, ADDR_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
    bus(1, ADDR_IRQ_STAT, 32'h0000_000F, 0);
    cyc(2);
    chk(irq_o, 1'b0);
    bus(1, ADDR_IRQ_MASK, 32'h0000_0000, 0);
    run_case(6'h0B);
    chk(irq_o, 1'b0);
    glitch(2'd0, 1'b1, 1'b0);
    glitch(2'd1, 1'b0, 1'b0);
    glitch(2'd2, 1'b1, 1'b1);
    // a start already running is dropped by a block and stays down
    fault <= 1'b1;
    cyc(25);
    block_i <= 1'b1;
    cyc(15);
    block_i <= 1'b0;
    cyc(40);
    chk({blocked_o, breaker_failure_output_o}, 2'b10);
    settle();
    chk(blocked_o, 1'b0);
    tally_and_finish();
  end
endmodule
